// >>> icr_input_path_regs.sv
// Operation
// - Shared three-bit filter cut-off, resets to 010.
// - Per-channel filter enable bit 15, resets off.
// - Pair oversample field sets microphone clock rate.
// - Pair reference select for microphone pins.
// - Pair mode field; oversample only in digital.
// - Gain code 40h-5Fh, analogue inputs only.
// - Sample delay 0-63, digital inputs only.
// - Left control mode governs both pair channels.
module icr_input_path_regs
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [icr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic [2:0] filter_cutoff_sel,
    output logic filter_cutoff_valid,
    output logic p1_left_filter_en,
    output logic p1_right_filter_en,
    output logic p2_left_filter_en,
    output logic [1:0] p1_input_type,
    output logic [1:0] p2_input_type,
    output logic p1_mic_clock_on,
    output logic p2_mic_clock_on,
    output logic [1:0] p1_mic_clock_rate,
    output logic [1:0] p2_mic_clock_rate,
    output logic [1:0] p1_mic_level_ref,
    output logic [1:0] p2_mic_level_ref,
    output logic [6:0] p1_left_gain,
    output logic [6:0] p1_right_gain,
    output logic [6:0] p2_left_gain,
    output logic p1_left_gain_on,
    output logic p1_right_gain_on,
    output logic p2_left_gain_on,
    output logic [5:0] p1_left_sample_delay,
    output logic [5:0] p1_right_sample_delay,
    output logic [5:0] p2_left_sample_delay
);

    // Current and next copy of all block state.
    icr_pkg::icr_state_t s;
    icr_pkg::icr_state_t next_s;

    // Per-channel decode of the stored registers.
    logic [2:0][1:0] ch_type;
    logic [2:0] ch_digital;
    logic [2:0] ch_analogue;
    logic [2:0] ch_gain_ok;
    logic [2:0][6:0] ch_gain;
    // Status word assembled from the decoded state.
    logic [15:0] status_word;
    // Setup phase and write strobe of the bus.
    logic setup_phase;
    logic write_strobe;

    // Merge the written byte lanes into a register and clear unassigned bits.
    function automatic logic [15:0] icr_merge
    (
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] st,
        input logic [15:0] msk
    );
        logic [15:0] lane;
        lane = {{8{st[1]}}, {8{st[0]}}};
        icr_merge = ((old & ~lane) | (wd[15:0] & lane)) & msk;
    endfunction : icr_merge

    // Decode each channel from its own register and its pair's left register.
    for (genvar c = 0; c < icr_pkg::NCH; c++)
    begin : g_ch
        // Both channels of a pair share the mode held in the left register.
        assign ch_type[c] =
            s.ctrl[icr_pkg::CH_LEFT[c]][icr_pkg::TYPE_HI:icr_pkg::TYPE_LO];
        // Only the digital code enables the microphone side of a pair.
        assign ch_digital[c] = (ch_type[c] == icr_pkg::TYPE_DIGITAL);
        // The reserved mode code is neither analogue nor digital.
        assign ch_analogue[c] = (ch_type[c] == icr_pkg::TYPE_DIFF)
            || (ch_type[c] == icr_pkg::TYPE_SINGLE);
        assign ch_gain[c] = s.ctrl[c][icr_pkg::GAIN_HI:icr_pkg::GAIN_LO];
        // Codes outside 0 dB to 31 dB are kept but not applied.
        assign ch_gain_ok[c] = (ch_gain[c] >= icr_pkg::GAIN_MIN)
            && (ch_gain[c] <= icr_pkg::GAIN_MAX);
    end

    // Status word; it is read only and reflects the decoded configuration.
    always_comb
    begin
        status_word = '0;
        status_word[icr_pkg::ST_CUT_OK] = s.cut_ok;
        for (int p = 0; p < icr_pkg::NPAIR; p++)
        begin
            status_word[icr_pkg::ST_DIGITAL + p] = s.mic_on[p];
            status_word[icr_pkg::ST_TYPE_BAD + p] = !ch_digital[2 * p] && !ch_analogue[2 * p];
        end
        for (int c = 0; c < icr_pkg::NCH; c++)
        begin
            status_word[icr_pkg::ST_GAIN_OK + c] = ch_gain_ok[c];
            status_word[icr_pkg::ST_GAIN_ON + c] = s.gain_on[c];
            status_word[icr_pkg::ST_DLY_ON + c] = ch_digital[c];
        end
    end

    // The slave never inserts wait states, so the access phase lasts one cycle.
    assign setup_phase = psel && !penable;
    assign write_strobe = psel && penable && pwrite && !s.slverr;
    assign pready = psel && penable;

    // Next state: bus decode, register writes and the registered path controls.
    always_comb
    begin
        next_s = s;

        // Read data and the error answer are prepared in the setup cycle, so they
        // come from flip-flops and are stable through the whole access phase.
        if (setup_phase)
        begin
            next_s.rdata = '0;
            next_s.slverr = 1'b1;
            // Misaligned addresses never match a register and so are refused.
            if (paddr == icr_pkg::ADDR_CUTOFF)
            begin
                next_s.rdata = {16'h0000, s.cut};
                next_s.slverr = 1'b0;
            end
            // The status word refuses writes; a read is answered normally.
            if (paddr == icr_pkg::ADDR_STATUS)
            begin
                next_s.rdata = {16'h0000, status_word};
                next_s.slverr = pwrite;
            end
            for (int c = 0; c < icr_pkg::NCH; c++)
            begin
                if (paddr == icr_pkg::ADDR_CTRL[c])
                begin
                    next_s.rdata = {16'h0000, s.ctrl[c]};
                    next_s.slverr = 1'b0;
                end
                if (paddr == icr_pkg::ADDR_DLY[c])
                begin
                    next_s.rdata = {16'h0000, s.dly[c]};
                    next_s.slverr = 1'b0;
                end
            end
        end

        // A write lands at the access edge; any stored code is kept as written.
        if (write_strobe)
        begin
            if (paddr == icr_pkg::ADDR_CUTOFF)
            begin
                next_s.cut = icr_merge(s.cut, pwdata, pstrb, icr_pkg::CUT_MASK);
            end
            for (int c = 0; c < icr_pkg::NCH; c++)
            begin
                if (paddr == icr_pkg::ADDR_CTRL[c])
                begin
                    next_s.ctrl[c] =
                        icr_merge(s.ctrl[c], pwdata, pstrb, icr_pkg::CTRL_MASK[c]);
                end
                if (paddr == icr_pkg::ADDR_DLY[c])
                begin
                    next_s.dly[c] =
                        icr_merge(s.dly[c], pwdata, pstrb, icr_pkg::DLY_MASK);
                end
            end
        end

        // One cut-off code serves every filter; reserved codes are flagged.
        next_s.cutoff = s.cut[icr_pkg::CUT_HI:0];
        next_s.cut_ok = (s.cut[icr_pkg::CUT_HI:0] <= icr_pkg::CUT_MAX);

        // Per-channel controls follow the stored registers one cycle later.
        for (int c = 0; c < icr_pkg::NCH; c++)
        begin
            // Each channel switches its own filter in or out.
            next_s.filt_en[c] = s.ctrl[c][icr_pkg::FILT_EN_BIT];
            next_s.gain[c] = ch_gain[c];
            // Gain only acts on an analogue input with a defined code.
            next_s.gain_on[c] = ch_analogue[c] && ch_gain_ok[c];
            // The delay only acts on a digital input; otherwise it reads as none.
            if (ch_digital[c])
            begin
                next_s.delay[c] = s.dly[c][icr_pkg::DLY_HI:0];
            end
            else
            begin
                next_s.delay[c] = '0;
            end
        end

        // Pair controls come from the left register of each pair.
        for (int p = 0; p < icr_pkg::NPAIR; p++)
        begin
            next_s.itype[p] = ch_type[2 * p];
            // The microphone clock runs only while the pair is in digital mode.
            next_s.mic_on[p] = ch_digital[2 * p];
            next_s.rate[p] = s.ctrl[2 * p][icr_pkg::RATE_HI:icr_pkg::RATE_LO];
            next_s.lref[p] = s.ctrl[2 * p][icr_pkg::REF_HI:icr_pkg::REF_LO];
        end
    end

    // State register; the reset image matches the documented field defaults.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s <= icr_pkg::ST_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Bus answer.
    assign prdata = s.rdata;
    assign pslverr = s.slverr;

    // Path controls, all taken straight from flip-flops.
    assign filter_cutoff_sel = s.cutoff;
    assign filter_cutoff_valid = s.cut_ok;
    assign p1_left_filter_en = s.filt_en[0];
    assign p1_right_filter_en = s.filt_en[1];
    assign p2_left_filter_en = s.filt_en[2];
    assign p1_input_type = s.itype[0];
    assign p2_input_type = s.itype[1];
    assign p1_mic_clock_on = s.mic_on[0];
    assign p2_mic_clock_on = s.mic_on[1];
    // The rate is meaningful only while the matching clock-on output is high.
    assign p1_mic_clock_rate = s.rate[0];
    assign p2_mic_clock_rate = s.rate[1];
    assign p1_mic_level_ref = s.lref[0];
    assign p2_mic_level_ref = s.lref[1];
    // Gain changes are not smoothed; software must change them with the path off.
    assign p1_left_gain = s.gain[0];
    assign p1_right_gain = s.gain[1];
    assign p2_left_gain = s.gain[2];
    assign p1_left_gain_on = s.gain_on[0];
    assign p1_right_gain_on = s.gain_on[1];
    assign p2_left_gain_on = s.gain_on[2];
    assign p1_left_sample_delay = s.delay[0];
    assign p1_right_sample_delay = s.delay[1];
    assign p2_left_sample_delay = s.delay[2];

endmodule : icr_input_path_regs

// >>> icr_input_path_regs_checker.sv
// Watches the register bank ports and ties the cut-off, pair 1 left filter enable and pair 2 mode outputs to their register writes.
module icr_checker
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [icr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [2:0] filter_cutoff_sel,
    input wire logic filter_cutoff_valid,
    input wire logic p1_left_filter_en,
    input wire logic [1:0] p1_input_type,
    input wire logic [1:0] p2_input_type,
    input wire logic p1_mic_clock_on,
    input wire logic [6:0] p1_left_gain,
    input wire logic p1_left_gain_on,
    input wire logic [5:0] p1_left_sample_delay
);
    // One clock domain, so one default clock and reset serve every property.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Path outputs follow a write one edge after the access edge and are sampled two edges on.
    property p_cut_write;
        psel && penable && pwrite && paddr == 12'hc30 && pstrb[0]
            |-> ##2 filter_cutoff_sel == $past(pwdata[2:0], 2);
    endproperty
    a_cut_write: assert property (p_cut_write) else $error("cutoff select not updated");
    property p_cut_valid;
        filter_cutoff_valid == (filter_cutoff_sel <= 3'h4);
    endproperty
    a_cut_valid: assert property (p_cut_valid) else $error("cutoff valid flag wrong");
    property p_filt_write;
        psel && penable && pwrite && paddr == 12'hc40 && pstrb[1]
            |-> ##2 p1_left_filter_en == $past(pwdata[15], 2);
    endproperty
    a_filt_write: assert property (p_filt_write) else $error("filter enable not updated");
    property p_type_write;
        psel && penable && pwrite && paddr == 12'hc60 && pstrb[1]
            |-> ##2 p2_input_type == $past(pwdata[10:9], 2);
    endproperty
    a_type_write: assert property (p_type_write) else $error("pair mode not updated");
    property p_mic_on;
        p1_mic_clock_on == (p1_input_type == 2'h2);
    endproperty
    a_mic_on: assert property (p_mic_on) else $error("mic clock on wrong");
    property p_gain_on;
        p1_left_gain_on == (!p1_input_type[1] && p1_left_gain >= 7'h40 && p1_left_gain <= 7'h5f);
    endproperty
    a_gain_on: assert property (p_gain_on) else $error("gain on flag wrong");
    property p_dly_off;
        !p1_mic_clock_on |-> p1_left_sample_delay == 6'h00;
    endproperty
    a_dly_off: assert property (p_dly_off) else $error("delay active in analogue mode");
    property p_misalign;
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
endmodule : icr_checker

bind icr_input_path_regs icr_checker u_chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pslverr, .filter_cutoff_sel, .filter_cutoff_valid,
    .p1_left_filter_en, .p1_input_type, .p2_input_type, .p1_mic_clock_on, .p1_left_gain,
    .p1_left_gain_on, .p1_left_sample_delay);

// >>> icr_pkg.sv
package icr_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [9:0] IDX_CUTOFF = 10'h30c;
    localparam logic [9:0] IDX_STATUS = 10'h30e;
    localparam logic [9:0] IDX_P1L_CTRL = 10'h310;
    localparam logic [9:0] IDX_P1L_DLY = 10'h312;
    localparam logic [9:0] IDX_P1R_CTRL = 10'h314;
    localparam logic [9:0] IDX_P1R_DLY = 10'h316;
    localparam logic [9:0] IDX_P2L_CTRL = 10'h318;
    localparam logic [9:0] IDX_P2L_DLY = 10'h31a;

    // Byte addresses, one aligned word per register.
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CUTOFF = {IDX_CUTOFF, 2'h0};
    localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

    // Per-channel tables, element 0 is path 1 left, 1 is path 1 right, 2 is path 2 left.
    localparam int NCH = 3;
    localparam int NPAIR = 2;
    localparam logic [2:0][11:0] ADDR_CTRL =
        {{IDX_P2L_CTRL, 2'h0}, {IDX_P1R_CTRL, 2'h0}, {IDX_P1L_CTRL, 2'h0}};
    localparam logic [2:0][11:0] ADDR_DLY =
        {{IDX_P2L_DLY, 2'h0}, {IDX_P1R_DLY, 2'h0}, {IDX_P1L_DLY, 2'h0}};
    // Index of the left control register that governs each channel's pair.
    localparam logic [2:0][1:0] CH_LEFT = {2'h2, 2'h0, 2'h0};

    // Field positions.
    localparam int CUT_HI = 2;
    localparam int FILT_EN_BIT = 15;
    localparam int RATE_HI = 14;
    localparam int RATE_LO = 13;
    localparam int REF_HI = 12;
    localparam int REF_LO = 11;
    localparam int TYPE_HI = 10;
    localparam int TYPE_LO = 9;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 1;
    localparam int DLY_HI = 5;

    // Field codes and limits.
    localparam logic [2:0] CUT_MAX = 3'h4;
    localparam logic [1:0] TYPE_DIFF = 2'h0;
    localparam logic [1:0] TYPE_SINGLE = 2'h1;
    localparam logic [1:0] TYPE_DIGITAL = 2'h2;
    localparam logic [6:0] GAIN_MIN = 7'h40;
    localparam logic [6:0] GAIN_MAX = 7'h5f;

    // Reset values of the fields.
    localparam logic [2:0] CUT_RST = 3'h2;
    localparam logic [1:0] RATE_RST = 2'h1;
    localparam logic [1:0] REF_RST = 2'h0;
    localparam logic [1:0] TYPE_RST = 2'h0;
    localparam logic [6:0] GAIN_RST = 7'h40;
    localparam logic [5:0] DLY_RST = 6'h00;

    // Writable bits of each register; all other bits read as zero.
    localparam logic [15:0] CUT_MASK = 16'h0007;
    localparam logic [15:0] CTRL_MASK_L = 16'hfefe;
    localparam logic [15:0] CTRL_MASK_R = 16'h80fe;
    localparam logic [15:0] DLY_MASK = 16'h003f;
    localparam logic [2:0][15:0] CTRL_MASK = {CTRL_MASK_L, CTRL_MASK_R, CTRL_MASK_L};

    // Whole-word reset images.
    localparam logic [15:0] CTRL_RST_L = 16'h2080;
    localparam logic [15:0] CTRL_RST_R = 16'h0080;

    // Status word bit positions.
    localparam int ST_CUT_OK = 0;
    localparam int ST_DIGITAL = 1;
    localparam int ST_TYPE_BAD = 3;
    localparam int ST_GAIN_OK = 5;
    localparam int ST_GAIN_ON = 8;
    localparam int ST_DLY_ON = 11;

    // All state of the register bank, registered as one word.
    typedef struct packed {
        logic [15:0] cut;
        logic [2:0][15:0] ctrl;
        logic [2:0][15:0] dly;
        logic [31:0] rdata;
        logic slverr;
        logic [2:0] filt_en;
        logic [2:0] gain_on;
        logic [2:0][6:0] gain;
        logic [2:0][5:0] delay;
        logic [1:0] mic_on;
        logic [1:0][1:0] rate;
        logic [1:0][1:0] lref;
        logic [1:0][1:0] itype;
        logic [2:0] cutoff;
        logic cut_ok;
    } icr_state_t;

    localparam icr_state_t ST_RESET = '{
        cut: {13'h0000, CUT_RST},
        ctrl: {CTRL_RST_L, CTRL_RST_R, CTRL_RST_L},
        dly: '0,
        rdata: '0,
        slverr: 1'b0,
        filt_en: '0,
        gain_on: 3'h7,
        gain: {GAIN_RST, GAIN_RST, GAIN_RST},
        delay: {DLY_RST, DLY_RST, DLY_RST},
        mic_on: '0,
        rate: {RATE_RST, RATE_RST},
        lref: {REF_RST, REF_RST},
        itype: {TYPE_RST, TYPE_RST},
        cutoff: CUT_RST,
        cut_ok: 1'b1
    };

endpackage : icr_pkg

// >>> tb_top.sv
// Self-checking bench: an APB master plus a word model of the seven registers.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, v, s;
    logic [3:0] pstrb;
    logic [2:0] filter_cutoff_sel;
    logic filter_cutoff_valid, p1_left_filter_en, p1_right_filter_en, p2_left_filter_en;
    logic p1_mic_clock_on, p2_mic_clock_on, p1_left_gain_on, p1_right_gain_on, p2_left_gain_on;
    logic [1:0] p1_input_type, p2_input_type, p1_mic_clock_rate, p2_mic_clock_rate;
    logic [1:0] p1_mic_level_ref, p2_mic_level_ref;
    logic [6:0] p1_left_gain, p1_right_gain, p2_left_gain;
    logic [5:0] p1_left_sample_delay, p1_right_sample_delay, p2_left_sample_delay;
    int n_mismatch, n_compared;
    // Model words; order is cutoff, p1l ctrl, p1l delay, p1r ctrl, p1r delay, p2l ctrl, p2l delay.
    logic [15:0] m [7];
    logic [11:0] ra [7] = '{12'hc30, 12'hc40, 12'hc48, 12'hc50, 12'hc58, 12'hc60, 12'hc68};
    logic [15:0] rm [7] = '{16'h0007, 16'hfefe, 16'h003f, 16'h80fe, 16'h003f, 16'hfefe, 16'h003f};

    icr_input_path_regs u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .filter_cutoff_sel, .filter_cutoff_valid, .p1_left_filter_en,
        .p1_right_filter_en, .p2_left_filter_en, .p1_input_type, .p2_input_type,
        .p1_mic_clock_on, .p2_mic_clock_on, .p1_mic_clock_rate, .p2_mic_clock_rate,
        .p1_mic_level_ref, .p2_mic_level_ref, .p1_left_gain, .p1_right_gain, .p2_left_gain,
        .p1_left_gain_on, .p1_right_gain_on, .p2_left_gain_on, .p1_left_sample_delay,
        .p1_right_sample_delay, .p2_left_sample_delay);

    // Free-running 100 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Fixed-seed xorshift so every run replays the same traffic.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Gain is live only in an analogue mode and a defined code.
    function automatic logic gon(logic [1:0] t, logic [6:0] g);
        return !t[1] && g >= 7'h40 && g <= 7'h5f;
    endfunction : gon

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One transfer; entered just after an edge and leaves the bus held, so transfers chain.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] st);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge mclk);
        penable <= 1'b1;
        // Wait for the answer however long it takes; only the watchdog ends a hang.
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
    endtask : apb

    // Release the bus; staying in access would repeat the transfer.
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask : idle

    // Write and update the model with byte lanes and the writable mask.
    task automatic wr(input int i, input logic [31:0] d, input logic [3:0] st);
        logic [15:0] bm;
        bm = {{8{st[1]}}, {8{st[0]}}};
        apb(1'b1, ra[i], d, st);
        m[i] = (m[i] & ~bm) | (d[15:0] & bm & rm[i]);
    endtask : wr

    task automatic rdc(input int i);
        apb(1'b0, ra[i], 32'h0, 4'h0);
        chk({pslverr, rd}, {1'b0, 16'h0, m[i]});
    endtask : rdc

    // All path outputs against what the model words imply.
    task automatic outs();
        logic [1:0] t1, t2;
        t1 = m[1][10:9];
        t2 = m[5][10:9];
        chk({p1_input_type, p1_mic_clock_on, p1_mic_clock_rate, p1_mic_level_ref,
            p1_left_filter_en, p1_left_gain, p1_left_gain_on, p1_left_sample_delay,
            p1_right_filter_en, p1_right_gain, p1_right_gain_on, p1_right_sample_delay},
            {t1, t1 == 2'h2, m[1][14:11], m[1][15], m[1][7:1], gon(t1, m[1][7:1]),
            t1 == 2'h2 ? m[2][5:0] : 6'h0, m[3][15], m[3][7:1], gon(t1, m[3][7:1]),
            t1 == 2'h2 ? m[4][5:0] : 6'h0});
        chk({p2_input_type, p2_mic_clock_on, p2_mic_clock_rate, p2_mic_level_ref,
            p2_left_filter_en, p2_left_gain, p2_left_gain_on, p2_left_sample_delay,
            filter_cutoff_sel, filter_cutoff_valid},
            {t2, t2 == 2'h2, m[5][14:11], m[5][15], m[5][7:1], gon(t2, m[5][7:1]),
            t2 == 2'h2 ? m[6][5:0] : 6'h0, m[0][2:0], m[0][2:0] <= 3'h4});
    endtask : outs

    // Read-only status word against the flags that the model words imply.
    task automatic stat();
        logic [1:0] t1, t2;
        t1 = m[1][10:9];
        t2 = m[5][10:9];
        apb(1'b0, 12'hc38, 32'h0, 4'h0);
        chk({pslverr, rd}, {1'b0, 18'h0, t2 == 2'h2, t1 == 2'h2, t1 == 2'h2,
            gon(t2, m[5][7:1]), gon(t1, m[3][7:1]), gon(t1, m[1][7:1]),
            gon(2'h0, m[5][7:1]), gon(2'h0, m[3][7:1]), gon(2'h0, m[1][7:1]),
            t2 == 2'h3, t1 == 2'h3, t2 == 2'h2, t1 == 2'h2, m[0][2:0] <= 3'h4});
    endtask : stat

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // Watchdog well beyond the fewer than a thousand cycles the tests need.
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        rst = 1'b1;
        seed = 32'h1750;
        m = '{16'h0002, 16'h2080, 16'h0, 16'h0080, 16'h0, 16'h2080, 16'h0};
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        outs();
        for (int i = 0; i < 7; i++)
            rdc(i);
        stat();
        $display("reset values done");
        // Every cut-off code, reserved ones included, written back to back with a read.
        for (int c = 0; c < 8; c++)
        begin
            v = xs();
            v[2:0] = c[2:0];
            wr(0, v, 4'hf);
            rdc(0);
            idle(2);
            outs();
            stat();
        end
        $display("cutoff codes done");
        // Each mode with boundary gain codes; other fields random.
        for (int k = 0; k < 16; k++)
        begin
            for (int i = 1; i < 7; i++)
            begin
                v = xs();
                v[7:1] = (k[1:0] == 2'h0) ? 7'h3f : (k[1:0] == 2'h1) ? 7'h40 :
                    (k[1:0] == 2'h2) ? 7'h5f : 7'h60;
                v[10:9] = k[3:2];
                // Path enables live outside this bank, so each gain write models a path that is off.
                wr(i, v, 4'hf);
            end
            idle(2);
            outs();
            stat();
        end
        $display("modes and gains done");
        // Random mix of lane-masked writes and reads.
        for (int n = 0; n < 200; n++)
        begin
            v = xs();
            s = xs();
            if (s[8])
                wr(int'(s[31:16] % 7), v, s[3:0]);
            else
                rdc(int'(s[31:16] % 7));
            if (s[11:9] == 3'h0)
            begin
                idle(2);
                outs();
            end
        end
        $display("random traffic done");
        // Pair 1 digital as a noise-cancel source keeps rate code 01.
        wr(1, 32'h3480, 4'hf);
        idle(2);
        outs();
        // Rate code 11 is written only with every path rate held in the low band.
        wr(1, 32'h7480, 4'hf);
        idle(2);
        outs();
        $display("software rate cases done");
        // Unmapped, misaligned and status writes are refused and change nothing.
        apb(1'b1, 12'hc34, 32'hffffffff, 4'hf);
        chk(pslverr, 1'b1);
        apb(1'b0, 12'hc34, 32'h0, 4'h0);
        chk({pslverr, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'hc41, 32'hffffffff, 4'hf);
        chk(pslverr, 1'b1);
        apb(1'b1, 12'hc38, 32'hffffffff, 4'hf);
        chk(pslverr, 1'b1);
        for (int i = 0; i < 7; i++)
            rdc(i);
        stat();
        idle(2);
        outs();
        $display("refused accesses done");
        summarize();
    end
endmodule : tb_top
